// ---- src/row_writer_pkg.sv ----
// Operation
// - the device holds a row of write latches with 96 bytes of program data, filled before a program starts.
// - each table write picks its latch by table pointer offset bits 5:1 alone; the page register takes no part.
// - a high-byte table write stores only the low byte of the source word and drops its upper byte.
// - no erase or program starts unless the unlock pair was written to the key register just before.
// - the page register resets to zero, holds only its low byte, and reads zero above it.
package row_writer_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  // the page register's offset is a word index; its byte address is four times it
  localparam logic [11:0] IDX_PAGE     = 12'h032;
  localparam logic [11:0] ADDR_PAGE    = IDX_PAGE << 2;
  localparam logic [11:0] ADDR_KEY     = 12'h040;
  localparam logic [11:0] ADDR_CTRL    = 12'h044;
  localparam logic [11:0] ADDR_TPTR    = 12'h048;
  localparam logic [11:0] ADDR_WLOW    = 12'h04c;
  localparam logic [11:0] ADDR_WHIGH   = 12'h050;
  localparam logic [11:0] ADDR_RDLAT   = 12'h054;
  // ---------------------------------------------------------------
  // fields and values
  // ---------------------------------------------------------------
  localparam int          CTRL_START_BIT = 15;
  localparam int          CTRL_ERR_BIT   = 13;
  localparam int          CTRL_ERASE_BIT = 6;
  localparam logic [7:0]  KEY_FIRST      = 8'h55;
  localparam logic [7:0]  KEY_SECOND     = 8'haa;
  localparam logic [15:0] PAGE_RESET     = 16'h0000;
  localparam logic [15:0] PAGE_MASK      = 16'h00ff;
  localparam int          ROW_WORDS      = 32;
  localparam int          ROW_BYTES      = 96;
  localparam int          WIDX_W         = 5;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          CLK_HZ         = 20_000_000;
  localparam int          PROG_TIME_US   = 2000;
  localparam int          PROG_CYCLES    = PROG_TIME_US * (CLK_HZ / 1_000_000);
endpackage : row_writer_pkg

// ---- src/row_latch_bank.sv ----
`timescale 1ns/1ps
module row_latch_bank (
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          wr_low_i,
  input  wire logic                          wr_high_i,
  input  wire logic [row_writer_pkg::WIDX_W-1:0] idx_i,
  input  wire logic [15:0]                   data_i,
  output logic      [23:0]                   rd_word_o
);
  import row_writer_pkg::*;

  logic [23:0] lat_ff     [ROW_WORDS];
  logic [23:0] nxt_lat    [ROW_WORDS];

  // ---------------------------------------------------------------
  // 32 words of 24 bits: 96 bytes
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < ROW_WORDS; i++) begin
      nxt_lat[i] = lat_ff[i];
    end
    if (wr_low_i) begin
      nxt_lat[idx_i][15:0] = data_i;
    end
    if (wr_high_i) begin
      nxt_lat[idx_i][23:16] = data_i[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < ROW_WORDS; i++) begin
        lat_ff[i] <= 24'h000000;
      end
    end else begin
      for (int i = 0; i < ROW_WORDS; i++) begin
        lat_ff[i] <= nxt_lat[i];
      end
    end
  end

  assign rd_word_o = lat_ff[idx_i];
endmodule : row_latch_bank

// ---- src/program_flash_row_writer.sv ----
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module program_flash_row_writer #(
  parameter int PROG_CYCLES_P = row_writer_pkg::PROG_CYCLES
) (
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESETN_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic             BUSY_O
);
  import row_writer_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_KEY1, ST_ARMED} unlock_e;
  typedef enum logic {PG_IDLE, PG_RUN} prog_e;

  logic [7:0]  page_ff,  nxt_page;
  logic [15:0] tptr_ff,  nxt_tptr;
  unlock_e     ul_ff,    nxt_ul;
  prog_e       pg_ff,    nxt_pg;
  logic [31:0] cnt_ff,   nxt_cnt;
  logic        erase_ff, nxt_erase;
  logic        err_ff,   nxt_err;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        rdy_ff,   nxt_rdy;
  logic        slv_ff,   nxt_slv;
  logic        busy_ff,  nxt_busy;

  logic        acc;
  logic        wr;
  logic        rd_acc;
  logic        idle_st;
  logic        wr_page;
  logic        wr_key;
  logic        wr_ctrl;
  logic        wr_tptr;
  logic        start_ok;
  logic        start_bad;
  logic        wr_low;
  logic        wr_high;
  logic [23:0] lat_word;
  logic [WIDX_W-1:0] lat_idx;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == ADDR_PAGE) || (a == ADDR_KEY) || (a == ADDR_CTRL) ||
             (a == ADDR_TPTR) || (a == ADDR_WLOW) || (a == ADDR_WHIGH) ||
             (a == ADDR_RDLAT);
  endfunction : mapped

  function automatic logic wr_to(input logic w, input logic [11:0] a, input logic [11:0] t);
    wr_to = w && (a == t);
  endfunction : wr_to

  // ---------------------------------------------------------------
  // apb decode: one wait state, answer registered after the taken edge
  // ---------------------------------------------------------------
  assign acc       = PSEL_I && PENABLE_I && !rdy_ff;
  assign wr        = acc && PWRITE_I;
  assign rd_acc    = acc && !PWRITE_I;
  assign idle_st   = (pg_ff == PG_IDLE);
  assign wr_page   = wr_to(wr, PADDR_I, ADDR_PAGE);
  assign wr_key    = wr_to(wr, PADDR_I, ADDR_KEY);
  assign wr_ctrl   = wr_to(wr, PADDR_I, ADDR_CTRL) && idle_st;
  assign wr_tptr   = wr_to(wr, PADDR_I, ADDR_TPTR);
  // table pointer: offset only, page not used; word index from offset bits 5:1
  assign lat_idx   = tptr_ff[WIDX_W:1];
  // row frozen while a program runs, so the cells see stable data
  assign wr_low    = wr_to(wr, PADDR_I, ADDR_WLOW) && idle_st;
  assign wr_high   = wr_to(wr, PADDR_I, ADDR_WHIGH) && idle_st;
  assign start_ok  = wr_ctrl && PWDATA_I[CTRL_START_BIT] && (ul_ff == ST_ARMED);
  assign start_bad = wr_ctrl && PWDATA_I[CTRL_START_BIT] && (ul_ff != ST_ARMED);

  row_latch_bank u_bank (
    .clk_i     (SYS_CLK_I),
    .rst_n_i   (RESETN_I),
    .wr_low_i  (wr_low),
    .wr_high_i (wr_high),
    .idx_i     (lat_idx),
    .data_i    (PWDATA_I[15:0]),
    .rd_word_o (lat_word)
  );

  // ---------------------------------------------------------------
  // unlock chain
  // ---------------------------------------------------------------
  // any write other than the next key breaks the chain, so a stray
  // store between the keys cannot arm the start
  always_comb begin
    nxt_ul = ul_ff;
    if (wr) begin
      unique case (ul_ff)
        ST_IDLE:  nxt_ul = (wr_key && PWDATA_I[7:0] == KEY_FIRST) ?
                           ST_KEY1 : ST_IDLE;
        ST_KEY1:  nxt_ul = (wr_key && PWDATA_I[7:0] == KEY_SECOND) ?
                           ST_ARMED : ST_IDLE;
        ST_ARMED: nxt_ul = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ul_ff <= ST_IDLE;
    end else begin
      ul_ff <= nxt_ul;
    end
  end

  // ---------------------------------------------------------------
  // page, pointer and control fields
  // ---------------------------------------------------------------
  always_comb begin
    nxt_page  = page_ff;
    nxt_tptr  = tptr_ff;
    nxt_erase = erase_ff;
    nxt_err   = err_ff;
    if (wr_page) begin
      nxt_page = PWDATA_I[7:0];
    end
    if (wr_tptr) begin
      nxt_tptr = PWDATA_I[15:0];
    end
    if (wr_high) begin
      nxt_tptr = tptr_ff + 16'h0002;
    end
    if (wr_ctrl) begin
      nxt_erase = PWDATA_I[CTRL_ERASE_BIT];
    end
    // a refused start stays flagged until a good start clears it
    if (start_ok) begin
      nxt_err = 1'b0;
    end else if (start_bad) begin
      nxt_err = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      page_ff  <= PAGE_RESET[7:0];
      tptr_ff  <= 16'h0000;
      erase_ff <= 1'b0;
      err_ff   <= 1'b0;
    end else begin
      page_ff  <= nxt_page;
      tptr_ff  <= nxt_tptr;
      erase_ff <= nxt_erase;
      err_ff   <= nxt_err;
    end
  end

  // ---------------------------------------------------------------
  // program sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_pg  = pg_ff;
    nxt_cnt = cnt_ff;
    unique case (pg_ff)
      PG_IDLE: begin
        if (start_ok) begin
          nxt_pg  = PG_RUN;
          nxt_cnt = 32'(PROG_CYCLES_P);
        end
      end
      PG_RUN: begin
        if (cnt_ff <= 32'h00000001) begin
          nxt_pg  = PG_IDLE;
          nxt_cnt = 32'h00000000;
        end else begin
          nxt_cnt = cnt_ff - 32'h00000001;
        end
      end
    endcase
    nxt_busy = (nxt_pg == PG_RUN);
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pg_ff   <= PG_IDLE;
      cnt_ff  <= 32'h00000000;
      busy_ff <= 1'b0;
    end else begin
      pg_ff   <= nxt_pg;
      cnt_ff  <= nxt_cnt;
      busy_ff <= nxt_busy;
    end
  end

  // ---------------------------------------------------------------
  // bus answer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_rdy   = acc;
    nxt_slv   = acc && !mapped(PADDR_I);
    nxt_rdata = rdata_ff;
    // writes and refused reads answer zero, never stale read data
    if (acc) begin
      nxt_rdata = 32'h00000000;
      if (rd_acc) begin
        unique case (PADDR_I)
          ADDR_PAGE:  nxt_rdata = {16'h0000, 8'h00, page_ff};
          ADDR_CTRL:  nxt_rdata = {16'h0000, (pg_ff == PG_RUN), 1'b0, err_ff,
                                   6'h00, erase_ff, 6'h00};
          ADDR_TPTR:  nxt_rdata = {16'h0000, tptr_ff};
          ADDR_RDLAT: nxt_rdata = {8'h00, lat_word};
          default:    nxt_rdata = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rdata_ff <= 32'h00000000;
      rdy_ff   <= 1'b0;
      slv_ff   <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rdy_ff   <= nxt_rdy;
      slv_ff   <= nxt_slv;
    end
  end

  assign PRDATA_O  = rdata_ff;
  assign PREADY_O  = rdy_ff;
  assign PSLVERR_O = slv_ff;
  assign BUSY_O    = busy_ff;
endmodule : program_flash_row_writer

// ---- sim/flash_writer_props.sv ----
`timescale 1ns/1ps
module flash_writer_props
  import row_writer_pkg::*;
#(
  parameter int PROG_CYCLES_P = 20
) (
  input wire logic        SYS_CLK_I,
  input wire logic        RESETN_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        BUSY_O
);
  int busy_cnt_ff;
  int nxt_busy_cnt;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESETN_I);
  always_comb nxt_busy_cnt = BUSY_O ? busy_cnt_ff + 1 : 0;
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) busy_cnt_ff <= 0;
    else busy_cnt_ff <= nxt_busy_cnt;
  end
  ready_wait_a: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O ##1 !PREADY_O)
    else $error("no one-cycle ready after access");
  err_zero_a: assert property (PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0)
    else $error("error answer malformed");
  page_upper_a: assert property (PREADY_O && !PWRITE_I && PADDR_I == ADDR_PAGE |-> PRDATA_O[31:8] == 0)
    else $error("page upper bits not zero");
  start_cause_a: assert property ($rose(BUSY_O) |-> $past(PWRITE_I && PADDR_I == ADDR_CTRL && PWDATA_I[CTRL_START_BIT]))
    else $error("busy without start write");
  busy_bound_a: assert property (busy_cnt_ff <= PROG_CYCLES_P + 2)
    else $error("busy never clears");
  busy_len_a: assert property ($fell(BUSY_O) |-> busy_cnt_ff >= PROG_CYCLES_P - 1)
    else $error("busy ended early");
  cover property ($rose(BUSY_O));
  cover property ($fell(BUSY_O));
  cover property (PSLVERR_O);
endmodule : flash_writer_props
bind program_flash_row_writer flash_writer_props #(.PROG_CYCLES_P(PROG_CYCLES_P)) u_props (
  .SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .BUSY_O(BUSY_O));

// ---- sim/core_model.sv ----
`timescale 1ns/1ps
module core_model
  import row_writer_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  input  wire logic [31:0] prdata_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic      [11:0] paddr_o,
  output logic      [31:0] pwdata_o
);
  logic [31:0] rd;
  logic        err;
  initial begin
    {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    {psel_o, pwrite_o, paddr_o, pwdata_o} <= {1'b1, w, a, d};
    @(posedge clk_i);
    penable_o <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk_i);
      if (pready_i) break;
    end
    rd = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // idle data must not look like the last write
    pwdata_o <= ~d;
    if (i == 16) begin
      testbench.n_errors++;
      testbench.stop_test();
    end
  endtask : xfer
  task automatic load_word(input logic [31:0] lo, input logic [31:0] hi);
    xfer(1'b1, ADDR_WLOW, lo);
    xfer(1'b1, ADDR_WHIGH, hi);
  endtask : load_word
  // keys and start back to back; with ok low a page write slips in between the keys
  task automatic unlock(input logic ok);
    xfer(1'b1, ADDR_KEY, 32'(KEY_FIRST));
    if (!ok) xfer(1'b1, ADDR_PAGE, 32'h0);
    xfer(1'b1, ADDR_KEY, 32'(KEY_SECOND));
    xfer(1'b1, ADDR_CTRL, 32'h1 << CTRL_START_BIT);
    repeat (2) @(posedge clk_i);
  endtask : unlock
endmodule : core_model

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import row_writer_pkg::*;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] r; logic e;} row_s;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int          n_errors = 0;
  int          num_checks = 0;
  int          k;
  row_s rows[7] = '{'{1, ADDR_PAGE, 32'habcd12f5, 0, 0}, '{0, ADDR_PAGE, 0, 32'hf5, 0},
    '{0, 12'h0fc, 0, 0, 1}, '{1, 12'h0fc, 32'hffffffff, 0, 1}, '{0, ADDR_PAGE, 0, 32'hf5, 0},
    '{1, ADDR_CTRL, 32'h1 << CTRL_ERASE_BIT, 0, 0}, '{0, ADDR_CTRL, 0, 32'h1 << CTRL_ERASE_BIT, 0}};
  always #25 clk = ~clk;
  core_model u_core (.clk_i(clk), .pready_i(pready), .pslverr_i(pslverr), .prdata_i(prdata),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
  // short program time keeps the run small
  program_flash_row_writer #(.PROG_CYCLES_P(20)) u_dut (.SYS_CLK_I(clk), .RESETN_I(rst_n),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .BUSY_O(busy));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("errors=%0d checks=%0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      u_core.xfer(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) check(u_core.rd, rows[i].r);
      check(32'(u_core.err), 32'(rows[i].e));
    end
    u_core.xfer(1'b1, ADDR_TPTR, 32'h0);
    for (int i = 0; i < ROW_WORDS; i++) u_core.load_word(32'h5a00 + i, 32'hee40 + i);
    for (int i = 0; i < ROW_WORDS; i++) begin
      u_core.xfer(1'b1, ADDR_TPTR, 32'(2 * i));
      u_core.xfer(1'b0, ADDR_RDLAT, 32'h0);
      check(u_core.rd, {8'h0, 8'h40 + 8'(i), 16'h5a00 + 16'(i)});
    end
    u_core.unlock(1'b0);
    check(32'(busy), 32'h0);
    u_core.xfer(1'b0, ADDR_CTRL, 32'h0);
    check(32'(u_core.rd[CTRL_ERR_BIT]), 32'h1);
    u_core.unlock(1'b1);
    check(32'(busy), 32'h1);
    for (k = 0; k < 40; k++) begin
      u_core.xfer(1'b0, ADDR_CTRL, 32'h0);
      if (!u_core.rd[CTRL_START_BIT]) break;
    end
    check(32'(u_core.rd[CTRL_START_BIT]), 32'h0);
    check(32'(u_core.rd[CTRL_ERR_BIT]), 32'h0);
    // leave non-reset values behind so the mid-run reset is visible
    u_core.xfer(1'b1, ADDR_PAGE, 32'h0000003c);
    u_core.xfer(1'b1, ADDR_TPTR, 32'h00000006);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    u_core.xfer(1'b0, ADDR_PAGE, 32'h0);
    check(u_core.rd, 32'(PAGE_RESET));
    u_core.xfer(1'b0, ADDR_TPTR, 32'h0);
    check(u_core.rd, 32'h00000000);
    stop_test();
  end
endmodule : testbench
